// [dv/bus_host_model.sv]
`timescale 1ns/100ps
// Behavioural two-wire host. Each bit takes four quarter periods, and the
// host drives only while the clock is low, outside start and stop.
module bus_host_model #(
	parameter int QTR_NS = 100
) (
	// Wire level and host drives.
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// Both lines are released while no transfer runs.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	// Start works from idle and as a repeated start alike.
	task automatic start();
		sda_oe_o = 1'b0;
		#QTR_NS scl_o = 1'b1;
		#QTR_NS sda_oe_o = 1'b1;
		#QTR_NS scl_o = 1'b0;
		#QTR_NS;
	endtask

	// Stop leaves both lines high.
	task automatic stop();
		sda_oe_o = 1'b1;
		#QTR_NS scl_o = 1'b1;
		#QTR_NS sda_oe_o = 1'b0;
		#QTR_NS;
	endtask

	// One clock pulse; the level is sampled mid-way through the high phase.
	task automatic clk_bit(input logic b, output logic r);
		sda_oe_o = ~b;
		#QTR_NS scl_o = 1'b1;
		#QTR_NS r = sda_i;
		#QTR_NS scl_o = 1'b0;
		#QTR_NS;
	endtask

	// Eight data pulses, MSB first, then the acknowledge pulse.
	task automatic xfer(input logic [7:0] d, input logic ack_bit,
		output logic [7:0] r, output logic ack);
		logic b;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], b);
			r = {r[6:0], b};
		end
		clk_bit(ack_bit, ack);
	endtask
endmodule // bus_host_model

// [dv/tilt_serial_port_tb_top.sv]
`timescale 1ns/100ps
module tilt_serial_port_tb_top
	import tilt_port_pkg::*;
;

	// ********************************************************************
	// Signals, clock and design.
	// ********************************************************************
	localparam logic [6:0] ADDR = 7'h14;
	// Arbitrary identification value.
	localparam logic [7:0] ID = 8'h3C;
	logic       clk;
	logic       rst_n;
	logic       scl;
	logic       sda;
	logic       h_oe;
	logic       d_out;
	logic       d_oe;
	logic       rd_pulse;
	logic       sleep;
	logic [7:0] x_s;
	logic [7:0] y_s;
	logic [7:0] st;
	logic [7:0] setup;
	logic [7:0] exp_rd [9];
	int         failures;
	int         checks_done;
	int         reads;

	// Open-drain wire with a pull-up: low while anyone pulls it.
	assign sda = (h_oe | (d_oe & ~d_out)) ? 1'b0 : 1'b1;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	tilt_serial_port #(.BUS_ADDR(ADDR), .PART_ID(ID)) tilt_serial_port_i (
		.CORE_CLK_I     (clk),
		.RST_N_I        (rst_n),
		.SCL_I          (scl),
		.SDA_I          (sda),
		.SDA_O          (d_out),
		.SDA_OE_O       (d_oe),
		.X_AXIS_SAMPLE_I(x_s),
		.Y_AXIS_SAMPLE_I(y_s),
		.STATE_I        (st),
		.STATE_READ_O   (rd_pulse),
		.DETECT_SETUP_O (setup),
		.SLEEP_REQUEST_O(sleep)
	);

	bus_host_model host_i (
		.sda_i   (sda),
		.scl_o   (scl),
		.sda_oe_o(h_oe)
	);

	// ********************************************************************
	// Checking and bus tasks.
	// ********************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
		logic [7:0] r;
		logic       a;
		host_i.xfer(d, 1'b1, r, a);
		check({7'h00, a}, {7'h00, exp_ack});
	endtask

	task automatic rd_byte(input logic [7:0] exp, input logic last);
		logic [7:0] r;
		logic       a;
		host_i.xfer(8'hFF, last, r, a);
		check(r, exp);
	endtask

	// Status loads are counted; each one clears the core's interrupt.
	always @(posedge clk) begin
		if (rd_pulse === 1'b1)
			reads++;
	end

	// The device may only move the data line while the clock is low.
	always @(d_oe) begin
		if (rst_n === 1'b1 && scl === 1'b1)
			check({7'h00, d_oe}, 8'hEE);
	end

	// A hang is cut short here.
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		final_report();
	end

	// ********************************************************************
	// Scenarios.
	// ********************************************************************
	initial begin
		failures = 0;
		checks_done = 0;
		reads = 0;
		rst_n = 1'b0;
		x_s = 8'h80;
		y_s = 8'h7F;
		st = 8'hA5;
		exp_rd = '{8'h80, 8'h7F, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, ID};
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check({7'h00, d_oe}, 8'h00);
		check(setup, SETUP_RESET);
		// Burst from 0: only the fifth byte lands, in the setup register.
		host_i.start();
		wr_byte({ADDR, 1'b0}, 1'b0);
		wr_byte(8'h00, 1'b0);
		wr_byte(8'h11, 1'b0);
		wr_byte(8'h22, 1'b0);
		wr_byte(8'h33, 1'b0);
		wr_byte(8'h44, 1'b0);
		wr_byte(8'h81, 1'b0);
		host_i.stop();
		check(setup, 8'h81);
		check({7'h00, sleep}, 8'h01);
		// Pointer write, repeated start, then a nine-byte read burst.
		host_i.start();
		wr_byte({ADDR, 1'b0}, 1'b0);
		wr_byte(8'h00, 1'b0);
		host_i.start();
		wr_byte({ADDR, 1'b1}, 1'b0);
		for (int i = 0; i < 9; i++) begin
			rd_byte(exp_rd[i], i == 8);
		end
		check({7'h00, d_oe}, 8'h00);
		host_i.stop();
		check(reads[7:0], 8'h01);
		// A foreign address is ignored until the next start.
		host_i.start();
		wr_byte({ADDR ^ 7'h01, 1'b0}, 1'b1);
		wr_byte(8'h04, 1'b1);
		host_i.stop();
		host_i.start();
		wr_byte({ADDR, 1'b0}, 1'b0);
		wr_byte(SETUP_IDX, 1'b0);
		wr_byte(8'h00, 1'b0);
		host_i.stop();
		check(setup, 8'h00);
		check({7'h00, sleep}, 8'h00);
		final_report();
	end
endmodule // tilt_serial_port_tb_top

// [include/tilt_port_pkg.sv]
package tilt_port_pkg;

	// ********************************************************************
	// Register map and field positions.
	// ********************************************************************
	localparam logic [7:0] X_SAMPLE_IDX  = 8'h00;
	localparam logic [7:0] Y_SAMPLE_IDX  = 8'h01;
	localparam logic [7:0] STATE_IDX     = 8'h02;
	localparam logic [7:0] SETUP_IDX     = 8'h04;
	localparam logic [7:0] PART_ID_IDX   = 8'h08;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;
	localparam logic [7:0] SETUP_RESET   = 8'h00;
	localparam logic [7:0] SAMPLE_RESET  = 8'h00;
	localparam int         SLEEP_BIT     = 7;
	localparam int         IRQ_BIT       = 7;

	// ********************************************************************
	// Bus framing constants.
	// ********************************************************************
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] DEFAULT_ADDR  = 7'h10;
	// Arbitrary identification value, not tied to any real part.
	localparam logic [7:0] DEFAULT_ID    = 8'h00;

	// Serial engine states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_ADDR   = 6'b00_0010,
		ST_ACK    = 6'b00_0100,
		ST_RXDATA = 6'b00_1000,
		ST_TXDATA = 6'b01_0000,
		ST_TXACK  = 6'b10_0000
	} serial_state_type;

endpackage

// [verilog/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync (
	// Clock and reset.
	input  wire logic CORE_CLK_I,
	input  wire logic RST_N_I,
	// Asynchronous pin and its synchronised copy.
	input  wire logic pin_i,
	output logic      sync_o
);

	logic meta_ff;

	// Two flops; the first is read only by the second. Idle bus rests high.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			meta_ff <= 1'b1;
			sync_o  <= 1'b1;
		end else begin
			meta_ff <= pin_i;
			sync_o  <= meta_ff;
		end
	end

endmodule // pin_sync

// [verilog/tilt_serial_port.sv]
`timescale 1ns/100ps
module tilt_serial_port
	import tilt_port_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h10,
	parameter logic [7:0] PART_ID  = DEFAULT_ID
) (
	// Clock and reset.
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_N_I,
	// Two-wire bus pins.
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	// Sensor core side.
	input  wire logic [7:0] X_AXIS_SAMPLE_I,
	input  wire logic [7:0] Y_AXIS_SAMPLE_I,
	input  wire logic [7:0] STATE_I,
	output logic            STATE_READ_O,
	output logic [7:0]      DETECT_SETUP_O,
	output logic            SLEEP_REQUEST_O
);

	// ********************************************************************
	// Pin synchronisation and edge detection.
	// ********************************************************************
	logic scl_s;
	logic sda_s;
	logic scl_d_ff;
	logic sda_d_ff;

	pin_sync u_scl_sync (
		.CORE_CLK_I (CORE_CLK_I),
		.RST_N_I    (RST_N_I),
		.pin_i      (SCL_I),
		.sync_o     (scl_s)
	);

	pin_sync u_sda_sync (
		.CORE_CLK_I (CORE_CLK_I),
		.RST_N_I    (RST_N_I),
		.pin_i      (SDA_I),
		.sync_o     (sda_s)
	);

	// Delayed copies give the edges of the synchronised lines.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	// Start and stop are data edges while clock stays high.
	wire scl_rise  = scl_s & ~scl_d_ff;
	wire scl_fall  = ~scl_s & scl_d_ff;
	wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// ********************************************************************
	// Serial engine state.
	// ********************************************************************
	serial_state_type state_ff;
	serial_state_type nxt_state;
	logic [7:0]       shift_ff;
	logic [3:0]       bit_cnt_ff;
	logic [7:0]       ptr_ff;
	logic             rd_dir_ff;
	logic             ptr_loaded_ff;
	logic             sda_low_ff;
	logic             host_nack_ff;
	logic [7:0]       setup_ff;

	// Register read decoding; unmapped and write-only numbers read zero.
	function automatic logic [7:0] read_reg(input logic [7:0] idx);
		case (idx)
			X_SAMPLE_IDX: read_reg = X_AXIS_SAMPLE_I;
			Y_SAMPLE_IDX: read_reg = Y_AXIS_SAMPLE_I;
			STATE_IDX:    read_reg = STATE_I;
			PART_ID_IDX:  read_reg = PART_ID;
			default:      read_reg = ZERO_BYTE;
		endcase
	endfunction

	// Byte the pointer selects; a process so that the sample inputs wake it.
	logic [7:0] rd_data;
	always_comb rd_data = read_reg(ptr_ff);

	wire [7:0] rx_byte    = {shift_ff[6:0], sda_s};
	wire       byte_done  = (bit_cnt_ff == BITS_PER_BYTE - 4'h1);
	wire       addr_match = (rx_byte[7:1] == BUS_ADDR);
	wire       setup_hit  = (ptr_ff == SETUP_IDX);
	wire [7:0] ptr_inc    = ptr_ff + 8'h01;
	wire       wr_commit  = (state_ff == ST_RXDATA) && scl_rise &&
	                        byte_done && ptr_loaded_ff;
	// The acknowledge slot opens on the eighth fall and ends on the ninth.
	wire       ack_slot   = (bit_cnt_ff != BITS_PER_BYTE);
	wire       ack_open   = (state_ff == ST_ACK) && scl_fall && !ack_slot;
	wire       ack_end    = (state_ff == ST_ACK) && scl_fall && ack_slot;
	wire       tx_load    = ack_end && rd_dir_ff;
	wire       tx_next    = (state_ff == ST_TXACK) && scl_rise && !sda_s;

	// Next-state decode; start from any state restarts address phase.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:   nxt_state = ST_IDLE;
			ST_ADDR:
				if (scl_rise && byte_done)
					nxt_state = addr_match ? ST_ACK : ST_IDLE;
			ST_ACK:
				if (ack_end)
					nxt_state = rd_dir_ff ? ST_TXDATA : ST_RXDATA;
			ST_RXDATA:
				if (scl_rise && byte_done)
					nxt_state = ST_ACK;
			ST_TXDATA:
				if (scl_fall && byte_done)
					nxt_state = ST_TXACK;
			ST_TXACK:
				if (scl_fall)
					nxt_state = host_nack_ff ? ST_IDLE : ST_TXDATA;
			default:   nxt_state = ST_IDLE;
		endcase
		if (start_det)
			nxt_state = ST_ADDR;
		else if (stop_det)
			nxt_state = ST_IDLE;
	end

	// State, bit counter and shift register follow the serial clock.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_ff   <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff   <= ZERO_BYTE;
		end else begin
			state_ff <= nxt_state;
			if (start_det || ack_end ||
			    (state_ff == ST_TXACK && scl_fall)) begin
				bit_cnt_ff <= 4'h0;
			end else if (ack_open) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end else if (scl_rise &&
			             (state_ff == ST_ADDR || state_ff == ST_RXDATA)) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				shift_ff   <= rx_byte;
			end else if (scl_fall && state_ff == ST_TXDATA) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				shift_ff   <= {shift_ff[6:0], 1'b0};
			end
			if (tx_load || (state_ff == ST_TXACK && scl_fall))
				shift_ff <= rd_data;
		end
	end

	// Direction, pointer and host acknowledge capture.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_dir_ff     <= 1'b0;
			ptr_loaded_ff <= 1'b0;
			ptr_ff        <= ZERO_BYTE;
			host_nack_ff  <= 1'b0;
		end else begin
			if (state_ff == ST_ADDR && scl_rise && byte_done) begin
				rd_dir_ff     <= sda_s;
				ptr_loaded_ff <= 1'b0;
			end
			if (state_ff == ST_RXDATA && scl_rise && byte_done) begin
				ptr_loaded_ff <= 1'b1;
				ptr_ff <= ptr_loaded_ff ? ptr_inc : rx_byte;
			end
			if (tx_next || (state_ff == ST_TXACK && scl_rise && sda_s))
				ptr_ff <= ptr_inc;
			if (state_ff == ST_TXACK && scl_rise)
				host_nack_ff <= sda_s;
		end
	end

	// Detection setup register; writes elsewhere are dropped.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			setup_ff <= SETUP_RESET;
		else if (wr_commit && setup_hit)
			setup_ff <= rx_byte;
	end

	// ********************************************************************
	// Open-drain data driver.
	// ********************************************************************
	// Changes on clock falls, and clears on a start or stop, so data is stable while clock is high.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			sda_low_ff <= 1'b0;
		else if (start_det || stop_det)
			sda_low_ff <= 1'b0;
		else if (scl_fall) begin
			case (nxt_state)
				ST_ACK:    sda_low_ff <= 1'b1;
				ST_TXDATA: sda_low_ff <= (state_ff == ST_ACK ||
				                          state_ff == ST_TXACK) ?
				                         ~rd_data[7] :
				                         ~shift_ff[6];
				default:   sda_low_ff <= 1'b0;
			endcase
		end
	end

	// Pin only pulled low or released; never driven high.
	assign SDA_O    = 1'b0;
	assign SDA_OE_O = sda_low_ff;

	// Status read strobe clears the core's pending flag.
	assign STATE_READ_O    = (tx_load || (state_ff == ST_TXACK && scl_fall &&
	                          !host_nack_ff)) && (ptr_ff == STATE_IDX);
	assign DETECT_SETUP_O  = setup_ff;
	assign SLEEP_REQUEST_O = setup_ff[SLEEP_BIT];

	// ********************************************************************
	// Checks.
	// ********************************************************************
	chk_sda_never_high: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I)
		SDA_O == 1'b0 && (state_ff != ST_IDLE || !SDA_OE_O))
		else $error("data line driven high or pulled while idle");
	chk_drive_clock_low: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) $changed(sda_low_ff) && !start_det &&
		!$past(start_det) |-> !$past(scl_s))
		else $error("data drive changed while clock high");
	chk_start_restarts: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) start_det |=> state_ff == ST_ADDR)
		else $error("start did not restart address phase");
	chk_stop_idles: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) stop_det && !start_det |=>
		state_ff == ST_IDLE && !sda_low_ff)
		else $error("stop did not idle the port");
	chk_addr_ack: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) state_ff == ST_ADDR && scl_rise &&
		byte_done && !addr_match && !start_det |=>
		state_ff == ST_IDLE)
		else $error("foreign address acknowledged");
	chk_ack_drives: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) state_ff == ST_ACK && ack_slot && scl_s |->
		sda_low_ff)
		else $error("acknowledge not held low");
	chk_txack_release: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) state_ff == ST_TXACK && scl_s |->
		!sda_low_ff)
		else $error("line not released for host acknowledge");
	chk_setup_write: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) wr_commit && setup_hit && !start_det |=>
		setup_ff == $past(rx_byte))
		else $error("setup write lost");
	chk_ptr_advance: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) tx_next |=>
		ptr_ff == $past(ptr_inc))
		else $error("pointer did not advance after read byte");
	chk_sleep_bit: assert property (@(posedge CORE_CLK_I)
		disable iff (!RST_N_I) $changed(SLEEP_REQUEST_O) |->
		$past(wr_commit && setup_hit))
		else $error("sleep request changed without a setup write");

	cov_write_setup: cover property (@(posedge CORE_CLK_I)
		wr_commit && setup_hit);
	cov_read_state: cover property (@(posedge CORE_CLK_I) STATE_READ_O);
	cov_host_nack: cover property (@(posedge CORE_CLK_I)
		state_ff == ST_TXACK && scl_rise && sda_s);
	cov_restart: cover property (@(posedge CORE_CLK_I)
		start_det && state_ff != ST_IDLE);

endmodule // tilt_serial_port
